// >>> port_policy_pkg.sv
// package: port policy table layout, encodings, register map
`default_nettype none
package port_policy_pkg;
    localparam int unsigned NUM_PORTS   = 11;
    localparam int unsigned PORT_W      = 4;
    localparam int unsigned ENTRY_W     = 117;
    localparam int unsigned WORDS_PER_E = 4;
    localparam logic [3:0]  CPU_PORT    = 4'ha;

    // field positions inside a 117-bit entry
    localparam int unsigned F_OP_LO   = 16;
    localparam int unsigned F_SEL_LO  = 56;
    localparam int unsigned F_VID_LO  = 58;
    localparam int unsigned F_DEI     = 70;
    localparam int unsigned F_PCP_LO  = 71;
    localparam int unsigned F_ORD_LO  = 74;
    localparam int unsigned F_MIN_LO  = 76;
    localparam int unsigned F_MAX_LO  = 78;
    localparam int unsigned F_SKIPM   = 80;
    localparam int unsigned F_LGRP    = 81;
    localparam int unsigned F_MIR     = 82;
    localparam int unsigned F_MMEM    = 83;
    localparam int unsigned F_MISO    = 84;
    localparam int unsigned F_MTGT_LO = 85;
    localparam int unsigned F_SPT_LO  = 89;
    localparam int unsigned F_PRIO    = 92;
    localparam int unsigned F_PVID_LO = 93;
    localparam int unsigned F_HOST    = 105;
    localparam int unsigned F_TXB     = 106;
    localparam int unsigned F_PTH     = 107;
    localparam int unsigned F_ROUTE   = 108;
    localparam int unsigned F_NATON   = 109;
    localparam int unsigned F_NATSIDE = 110;
    localparam int unsigned F_L2ON    = 111;
    localparam int unsigned F_L2FLAG  = 112;
    localparam int unsigned F_ACLMISS = 113;
    localparam int unsigned F_ACLFRC  = 114;
    localparam int unsigned F_PRE_LO  = 115;

    // reset entry: only the maximum tag count is non-zero (code 2)
    localparam logic [ENTRY_W-1:0] ENTRY_RESET = {{(ENTRY_W-80){1'b0}}, 2'h2, {78{1'b0}}};

    // register map: entry e word w at byte (e*4+w)*4; counters above
    localparam logic [9:0] TABLE_LIMIT   = 10'h0b0;
    localparam logic [9:0] CNT_MIN_ADDR  = 10'h100;
    localparam logic [9:0] CNT_MAX_ADDR  = 10'h104;
    localparam logic [9:0] CNT_MEMB_ADDR = 10'h108;
    localparam int unsigned CNT_W        = 32;

    typedef enum logic [1:0] {SRC_OUTER, SRC_PORT, SRC_MIXED, SRC_RSVD} vid_src_t;
    typedef enum logic [2:0] {OP_NONE, OP_SWAP, OP_PUSH, OP_POP, OP_STRIP,
                              OP_R5, OP_R6, OP_R7} tag_op_t;
    typedef enum logic [2:0] {STP_DISABLED, STP_BLOCKING, STP_LISTENING, STP_LEARNING,
                              STP_FORWARDING, STP_R5, STP_R6, STP_R7} stp_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  src_port;
        logic [1:0]  tag_count;
        logic        outer_direct;
        logic [11:0] outer_vid;
        logic [2:0]  outer_pcp;
        logic        outer_dei;
        logic [11:0] inner_vid;
        logic [2:0]  inner_pcp;
        logic        inner_dei;
        logic        group_source;
        logic [10:0] vlan_members;
        logic [10:0] mirror_isolation;
        logic [10:0] l2_dest_mask;
        logic        range_hit;
        logic [11:0] range_vid;
        logic [1:0]  range_order;
        logic        acl_hit;
        logic        tunnel_first_hit;
        logic        tunnel_second_hit;
    } frame_desc_t;

    typedef struct packed {
        logic        valid;
        logic        drop;
        logic [11:0] vid;
        logic [2:0]  pcp;
        logic        dei;
        logic [2:0]  queue_pcp;
        tag_op_t     tag_op;
        stp_t        stp_state;
        logic        may_learn_group;
        logic [10:0] dest_mask;
        logic        mirror_valid;
        logic [3:0]  mirror_port;
        logic        host_tag_decode;
        logic        tunnel_exit_ok;
        logic        tunnel_to_host;
        logic        routing_ok;
        logic        nat_check;
        logic        nat_public;
        logic        l2_action_lookup;
        logic        l2_action_flag;
        logic        use_fallback_acl;
        logic [1:0]  acl_prelookup_tag;
        logic        strip_prio_tag;
    } policy_result_t;
endpackage : port_policy_pkg
`default_nettype wire

// >>> ingress_port_vlan_policy.sv
// ingress per-port vlan policy with wishbone-held port table
// Contract
// - vid source: outer, port default, inner-if-two
// - missing selected tag falls back to default
// - untagged frames get default vid/dei/pcp
// - range hit replaces vid if order higher
// - minimum tag count check, drop and count
// - maximum tag count check, drop and count
// - non-member source dropped unless skip set
// - never forward to non-member destinations
// - learn group source only when enabled
// - mirror copy to target port when enabled
// - suppress mirror to non-member target
// - suppress mirror to isolating target
// - three-bit ingress spanning tree state
// - priority tag gives pcp, then bypassed
// - cpu port always decodes host tag
// - tunnel exit blocked when bit one
// - partial tunnel hit goes to host
// - routing permitted when bit one
// - nat check enable and port side
// - l2 action lookup enable and flag
// - fallback acl on miss when enabled
// - forced fallback acl, shared prelookup bits
// - three-bit per-port tag operation
`default_nettype none
module ingress_port_vlan_policy
    import port_policy_pkg::*;
(
    // clock and reset
    input  wire logic           clock_i,
    input  wire logic           nrst_i,
    // wishbone slave
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [9:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic      [31:0]    wb_dat_o,
    output logic                wb_ack_o,
    // frame descriptors
    input  wire frame_desc_t    frame_i,
    output policy_result_t      result_o
);
    logic [ENTRY_W-1:0]        table_q [NUM_PORTS];
    logic [CNT_W-1:0]          cnt_min_q;
    logic [CNT_W-1:0]          cnt_max_q;
    logic [CNT_W-1:0]          cnt_memb_q;

    // ---------------- bus slave ----------------
    logic                      req;
    logic [3:0]                rd_entry;
    logic [1:0]                rd_word;
    logic [127:0]              rd_wide;
    logic [31:0]               rd_d;

    // ack masks the held request so each bus cycle is taken once
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_entry = wb_adr_i[7:4];
    assign rd_word  = wb_adr_i[3:2];

    always_comb begin
        rd_wide = '0;
        rd_d    = '0;
        if (wb_adr_i < TABLE_LIMIT) begin
            rd_wide = {{(128-ENTRY_W){1'b0}}, table_q[rd_entry]};
            rd_d    = rd_wide[{rd_word, 5'h00} +: 32];
        end else if (wb_adr_i == CNT_MIN_ADDR) begin
            rd_d = cnt_min_q;
        end else if (wb_adr_i == CNT_MAX_ADDR) begin
            rd_d = cnt_max_q;
        end else if (wb_adr_i == CNT_MEMB_ADDR) begin
            rd_d = cnt_memb_q;
        end
    end

    // registered ack: a write lands on the edge that raises it
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_dat_o <= '0;
        end else begin
            wb_dat_o <= req ? rd_d : '0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_entry
            logic [127:0] wide;
            logic [127:0] merged;
            always_comb begin
                wide   = {{(128-ENTRY_W){1'b0}}, table_q[g]};
                merged = wide;
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        merged[{rd_word, 5'h00} + 7'(b*8) +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    table_q[g] <= ENTRY_RESET;
                end else if (req && wb_we_i && wb_adr_i < TABLE_LIMIT
                             && rd_entry == 4'(g)) begin
                    table_q[g] <= merged[ENTRY_W-1:0];
                end
            end
        end
    endgenerate

    // ---------------- per-frame policy ----------------
    logic [ENTRY_W-1:0]        e;
    logic                      port_ok;
    logic                      prio_match;
    logic [1:0]                eff_cnt;
    logic [11:0]               eff_outer_vid;
    logic [2:0]                eff_outer_pcp;
    logic                      eff_outer_dei;
    logic [11:0]               fb_vid;
    logic [11:0]               sel_vid;
    logic [11:0]               fin_vid;
    logic                      min_fail;
    logic                      max_fail;
    logic                      memb_fail;
    logic                      src_member;
    logic                      mirror_ok;
    logic [3:0]                mtgt;

    // entry fields used by the policy
    logic [1:0]                sel_code;
    logic [1:0]                ord_code;
    logic [1:0]                min_code;
    logic [1:0]                max_code;
    logic [2:0]                port_pcp;
    logic                      port_dei;
    logic [11:0]               prio_vid;
    logic                      skip_memb;

    // source ports beyond the table see the reset entry
    assign port_ok = frame_i.src_port < 4'(NUM_PORTS);
    assign e       = port_ok ? table_q[frame_i.src_port] : ENTRY_RESET;
    assign fb_vid  = e[F_VID_LO +: 12];
    assign mtgt    = e[F_MTGT_LO +: 4];

    assign sel_code  = e[F_SEL_LO +: 2];
    assign ord_code  = e[F_ORD_LO +: 2];
    assign min_code  = e[F_MIN_LO +: 2];
    assign max_code  = e[F_MAX_LO +: 2];
    assign port_pcp  = e[F_PCP_LO +: 3];
    assign port_dei  = e[F_DEI];
    assign prio_vid  = e[F_PVID_LO +: 12];
    assign skip_memb = e[F_SKIPM];

    // matched priority tag is removed from vlan view; inner becomes outer
    assign prio_match = e[F_PRIO] && frame_i.outer_direct && frame_i.tag_count != 2'h0
                        && frame_i.outer_vid == prio_vid;
    assign eff_cnt       = prio_match ? frame_i.tag_count - 2'h1 : frame_i.tag_count;
    assign eff_outer_vid = prio_match ? frame_i.inner_vid : frame_i.outer_vid;
    assign eff_outer_pcp = prio_match ? frame_i.inner_pcp : frame_i.outer_pcp;
    assign eff_outer_dei = prio_match ? frame_i.inner_dei : frame_i.outer_dei;

    always_comb begin
        unique case (vid_src_t'(sel_code))
            SRC_OUTER: sel_vid = (eff_cnt != 2'h0) ? eff_outer_vid : fb_vid;
            SRC_PORT:  sel_vid = fb_vid;
            SRC_MIXED: sel_vid = (eff_cnt >= 2'h2) ? frame_i.inner_vid : fb_vid;
            default:   sel_vid = fb_vid;
        endcase
    end

    // a range hit wins only with an order above the port's own
    always_comb begin
        fin_vid = sel_vid;
        if (frame_i.range_hit && frame_i.range_order > ord_code) begin
            fin_vid = frame_i.range_vid;
        end
    end

    always_comb begin
        unique case (min_code)
            2'h0:    min_fail = 1'b0;
            2'h1:    min_fail = eff_cnt < 2'h1;
            2'h2:    min_fail = eff_cnt < 2'h2;
            default: min_fail = 1'b1;
        endcase
    end

    always_comb begin
        unique case (max_code)
            2'h0:    max_fail = eff_cnt > 2'h0;
            2'h1:    max_fail = eff_cnt > 2'h1;
            default: max_fail = 1'b0;
        endcase
    end

    assign src_member = port_ok && frame_i.vlan_members[frame_i.src_port];
    assign memb_fail  = !src_member && !skip_memb;
    assign mirror_ok  = e[F_MIR] && mtgt < 4'(NUM_PORTS)
                        && !(e[F_MMEM] && !frame_i.vlan_members[mtgt])
                        && !(e[F_MISO] && frame_i.mirror_isolation[mtgt]);

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.valid <= 1'b0;
            result_o.drop  <= 1'b0;
        end else begin
            result_o.valid <= frame_i.valid;
            result_o.drop  <= frame_i.valid && (min_fail || max_fail || memb_fail);
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.vid <= '0;
        end else begin
            result_o.vid <= fin_vid;
        end
    end

    // untagged frames carry the port default tag fields
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.pcp <= '0;
            result_o.dei <= 1'b0;
        end else begin
            result_o.pcp <= (eff_cnt == 2'h0) ? port_pcp : eff_outer_pcp;
            result_o.dei <= (eff_cnt == 2'h0) ? port_dei : eff_outer_dei;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.queue_pcp      <= '0;
            result_o.strip_prio_tag <= 1'b0;
        end else begin
            result_o.queue_pcp      <= prio_match ? frame_i.outer_pcp
                                       : ((eff_cnt == 2'h0) ? port_pcp : eff_outer_pcp);
            result_o.strip_prio_tag <= prio_match;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.tag_op <= OP_NONE;
        end else begin
            result_o.tag_op <= tag_op_t'(e[F_OP_LO +: 3]);
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.stp_state <= STP_DISABLED;
        end else begin
            result_o.stp_state <= stp_t'(e[F_SPT_LO +: 3]);
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.may_learn_group <= 1'b0;
        end else begin
            result_o.may_learn_group <= frame_i.group_source ? e[F_LGRP] : 1'b1;
        end
    end

    // membership limits destinations even when the source check is skipped
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.dest_mask <= '0;
        end else begin
            result_o.dest_mask <= frame_i.l2_dest_mask & frame_i.vlan_members;
        end
    end

    // a failed guard drops the copy, never the frame itself
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.mirror_valid <= 1'b0;
            result_o.mirror_port  <= '0;
        end else begin
            result_o.mirror_valid <= frame_i.valid && mirror_ok;
            result_o.mirror_port  <= mtgt;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.host_tag_decode <= 1'b0;
        end else begin
            result_o.host_tag_decode <= (frame_i.src_port == CPU_PORT) || e[F_HOST];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.tunnel_exit_ok <= 1'b0;
            result_o.tunnel_to_host <= 1'b0;
        end else begin
            result_o.tunnel_exit_ok <= !e[F_TXB];
            result_o.tunnel_to_host <= e[F_PTH] && frame_i.tunnel_first_hit
                                       && !frame_i.tunnel_second_hit;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.routing_ok <= 1'b0;
            result_o.nat_check  <= 1'b0;
            result_o.nat_public <= 1'b0;
        end else begin
            result_o.routing_ok <= e[F_ROUTE];
            result_o.nat_check  <= e[F_NATON];
            result_o.nat_public <= e[F_NATSIDE];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.l2_action_lookup <= 1'b0;
            result_o.l2_action_flag   <= 1'b0;
        end else begin
            result_o.l2_action_lookup <= e[F_L2ON];
            result_o.l2_action_flag   <= e[F_L2FLAG];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_o.use_fallback_acl  <= 1'b0;
            result_o.acl_prelookup_tag <= '0;
        end else begin
            result_o.use_fallback_acl  <= e[F_ACLFRC] || (e[F_ACLMISS] && !frame_i.acl_hit);
            result_o.acl_prelookup_tag <= e[F_PRE_LO +: 2];
        end
    end

    // drop counters, one step per offending frame
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_min_q <= '0;
        end else begin
            if (frame_i.valid && min_fail) begin
                cnt_min_q <= cnt_min_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_max_q <= '0;
        end else begin
            if (frame_i.valid && max_fail) begin
                cnt_max_q <= cnt_max_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_memb_q <= '0;
        end else begin
            if (frame_i.valid && memb_fail) begin
                cnt_memb_q <= cnt_memb_q + 32'h1;
            end
        end
    end
endmodule : ingress_port_vlan_policy
`default_nettype wire

// >>> ingress_port_vlan_policy_chk.sv
// assertion checker for the ingress port vlan policy block
`default_nettype none
module ingress_port_vlan_policy_chk
    import port_policy_pkg::*;
(
    // clock and reset
    input  wire logic           clock_i,
    input  wire logic           nrst_i,
    // wishbone slave
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [9:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    input  wire logic [31:0]    wb_dat_o,
    input  wire logic           wb_ack_o,
    // frame descriptors
    input  wire frame_desc_t    frame_i,
    input  wire policy_result_t result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ANSWER: assert property (s_req |=> s_ack_once)
        else $error("ack not a single pulse after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero while idle");
    AST_RESULT_VALID: assert property (result_o.valid == $past(frame_i.valid))
        else $error("result valid not one cycle after frame");
    AST_DEST_MEMBERS: assert property (
        result_o.valid |-> (result_o.dest_mask & ~$past(frame_i.vlan_members)) == 11'h0)
        else $error("destination outside vlan");
    AST_HOST_PORT: assert property (
        $past(frame_i.valid && frame_i.src_port == CPU_PORT) |-> result_o.host_tag_decode)
        else $error("cpu port did not decode host tag");
    AST_PARTIAL_TUNNEL: assert property (
        result_o.valid && result_o.tunnel_to_host
        |-> $past(frame_i.tunnel_first_hit && !frame_i.tunnel_second_hit))
        else $error("tunnel to host without partial hit");
    AST_GROUP_LEARN: assert property (
        $past(frame_i.valid && !frame_i.group_source) |-> result_o.may_learn_group)
        else $error("unicast source not learnable");
    AST_PRIO_STRIP: assert property (
        result_o.valid && result_o.strip_prio_tag
        |-> $past(frame_i.outer_direct && frame_i.tag_count != 2'h0))
        else $error("priority tag stripped without outer tag");
    AST_MIRROR_RANGE: assert property (
        result_o.valid && result_o.mirror_valid |-> result_o.mirror_port < 4'(NUM_PORTS))
        else $error("mirror to absent port");
endmodule : ingress_port_vlan_policy_chk
bind ingress_port_vlan_policy ingress_port_vlan_policy_chk i_ingress_port_vlan_policy_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_i(frame_i), .result_o(result_o));
`default_nettype wire

// >>> frame_source_model.sv
// ingress port model: one descriptor per request, idle fields scrambled
`default_nettype none
module frame_source_model
    import port_policy_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    // request from the bench
    input  wire logic        send_i,
    input  wire frame_desc_t desc_i,
    // descriptor towards the policy block
    output frame_desc_t      frame_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle cycles invert the stale payload so no leftover value passes for a frame
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) frame_o <= '0;
        else if (send_i) frame_o <= desc_i;
        else frame_o <= {1'b0, ~frame_o[$bits(frame_desc_t)-2:0]};
    end
endmodule : frame_source_model
`default_nettype wire

// >>> tb_ingress_port_vlan_policy.sv
// self-checking bench for the ingress port vlan policy block
`default_nettype none
module tb_ingress_port_vlan_policy;
    import port_policy_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic           clock_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, we = 1'b0, send = 1'b0, ack, b;
    logic [9:0]     adr = 10'h000;
    logic [31:0]    wdat = 32'h0, rdat, dat_o;
    logic [127:0]   cfg = '0;
    frame_desc_t    d = '0, f = '0, frame;
    policy_result_t res;
    int             err_total = 0, checks = 0;
    always #2.5 clock_i = ~clock_i;
    frame_source_model i_frame_source_model (.clock_i(clock_i), .nrst_i(nrst_i),
        .send_i(send), .desc_i(d), .frame_o(frame));
    ingress_port_vlan_policy i_ingress_port_vlan_policy (.clock_i(clock_i), .nrst_i(nrst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .frame_i(frame), .result_o(res));
    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v);
        @(posedge clock_i);
        cyc <= 1'b1; we <= w; adr <= a; wdat <= v;
        do begin
            @(posedge clock_i);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0; we <= 1'b0;
    endtask : bus
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd
    task automatic put();
        for (int w = 0; w < 4; w++) bus(1'b1, 10'(w * 4), cfg[w*32 +: 32]);
    endtask : put
    task automatic frm();
        @(posedge clock_i);
        send <= 1'b1; d <= f;
        @(posedge clock_i);
        send <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask : frm
    task automatic tagcase(input logic [1:0] mn, mx, tg, input logic dr, input int cn, cx);
        cfg[F_MIN_LO +: 2] = mn; cfg[F_MAX_LO +: 2] = mx; put();
        f.tag_count = tg; frm();
        chk(32'(res.drop), 32'(dr));
        rd(CNT_MIN_ADDR, 32'(cn));
        rd(CNT_MAX_ADDR, 32'(cx));
    endtask : tagcase
    initial begin
        #50us;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(10'h008, 32'h00008000);
        bus(1'b1, CNT_MIN_ADDR, 32'h5);
        rd(CNT_MIN_ADDR, 32'h0);
        rd(10'h0c0, 32'h0);
        f.valid = 1'b1; f.vlan_members = 11'h7ff; f.l2_dest_mask = 11'h7ff;
        f.outer_vid = 12'h456; f.inner_vid = 12'h789; f.outer_direct = 1'b1;
        cfg[F_VID_LO +: 12] = 12'h123; cfg[F_DEI] = 1'b1; cfg[F_PCP_LO +: 3] = 3'h5;
        cfg[F_MAX_LO +: 2] = 2'h2;
        for (int s = 0; s < 4; s++) begin
            cfg[F_SEL_LO +: 2] = 2'(s);
            put();
            for (int t = 0; t < 3; t++) begin
                f.tag_count = 2'(t);
                frm();
                chk(32'(res.vid), (s == 0 && t > 0) ? 32'h456 : (s == 2 && t == 2) ? 32'h789 : 32'h123);
                if (t == 0) chk(32'({res.dei, res.pcp}), 32'hd);
            end
        end
        cfg[F_SEL_LO +: 2] = 2'h0;
        tagcase(2'h2, 2'h0, 2'h1, 1'b1, 1, 1);
        tagcase(2'h3, 2'h3, 2'h2, 1'b1, 2, 1);
        tagcase(2'h1, 2'h1, 2'h1, 1'b0, 2, 1);
        tagcase(2'h0, 2'h1, 2'h2, 1'b1, 2, 2);
        tagcase(2'h1, 2'h2, 2'h0, 1'b1, 3, 2);
        cfg[F_MIN_LO +: 2] = 2'h0; cfg[F_MAX_LO +: 2] = 2'h2; put();
        f.tag_count = 2'h1; f.vlan_members = 11'h7fe; frm();
        chk(32'(res.drop), 32'h1);
        rd(CNT_MEMB_ADDR, 32'h1);
        cfg[F_SKIPM] = 1'b1; cfg[F_ORD_LO +: 2] = 2'h1; put(); frm();
        chk(32'({res.drop, res.dest_mask}), 32'h7fe);
        f.range_hit = 1'b1; f.range_vid = 12'habc; f.range_order = 2'h1; frm();
        chk(32'(res.vid), 32'h456);
        f.range_order = 2'h2; frm();
        chk(32'(res.vid), 32'habc);
        f.range_hit = 1'b0; f.vlan_members = 11'h7f7;
        cfg[F_MIR] = 1'b1; cfg[F_MMEM] = 1'b1; cfg[F_MTGT_LO +: 4] = 4'h3; put(); frm();
        chk(32'(res.mirror_valid), 32'h0);
        f.vlan_members = 11'h7ff; frm();
        chk(32'({res.mirror_valid, res.mirror_port}), 32'h13);
        cfg[F_MISO] = 1'b1; put(); f.mirror_isolation = 11'h008; frm();
        chk(32'(res.mirror_valid), 32'h0);
        f.tunnel_first_hit = 1'b1; f.group_source = 1'b1; cfg[F_PVID_LO +: 12] = 12'h456;
        f.outer_pcp = 3'h6;
        for (int k = 0; k < 5; k++) begin
            b = k[0];
            cfg[F_OP_LO +: 3] = 3'(k); cfg[F_SPT_LO +: 3] = 3'(k);
            cfg[F_TXB +: 10] = {10{b}}; cfg[F_ACLFRC] = (k == 4); cfg[F_PRE_LO +: 2] = {b, b};
            cfg[F_HOST] = b; cfg[F_LGRP] = b; cfg[F_PRIO] = b; f.acl_hit = (k == 4);
            put(); frm();
            chk(32'({res.tag_op, res.stp_state, res.tunnel_exit_ok, res.tunnel_to_host,
                res.routing_ok, res.nat_check, res.nat_public, res.l2_action_lookup,
                res.l2_action_flag, res.use_fallback_acl, res.acl_prelookup_tag,
                res.host_tag_decode, res.may_learn_group, res.strip_prio_tag}),
                32'({3'(k), 3'(k), ~b, {6{b}}, b | (k == 4), {5{b}}}));
            chk(32'({res.queue_pcp, res.pcp}), 32'({3'h6, b ? 3'h5 : 3'h6}));
        end
        f.src_port = CPU_PORT; frm();
        chk(32'(res.host_tag_decode), 32'h1);
        report_and_stop();
    end
endmodule : tb_ingress_port_vlan_policy
`default_nettype wire
